// ==== fssct_pkg.sv ====
/*
  Shared constants and types for the floating point store, subtract and
  compare timing block: opcode bytes, clock counts and decode flags.
  Assumes the integer unit presents one two-byte opcode at a time.
*/
`default_nettype none
package fssct_pkg;

  localparam logic [7:0] OPB_D8 = 8'hD8;
  localparam logic [7:0] OPB_D9 = 8'hD9;
  localparam logic [7:0] OPB_DA = 8'hDA;
  localparam logic [7:0] OPB_DB = 8'hDB;
  localparam logic [7:0] OPB_DC = 8'hDC;
  localparam logic [7:0] OPB_DD = 8'hDD;
  localparam logic [7:0] OPB_DE = 8'hDE;
  localparam logic [7:0] OPB_DF = 8'hDF;
  localparam logic [7:0] OPB_WAIT = 8'h9B;

  localparam int RSVD_N = 10;
  localparam logic [15:0] RSVD_OPS [RSVD_N] = '{
    16'hD9D7, 16'hD9E2, 16'hD9E7, 16'hDDFC, 16'hDED8,
    16'hDEDA, 16'hDEDC, 16'hDEDD, 16'hDEDE, 16'hDFFC};

  // Clock counts, in core clocks.
  localparam logic [7:0] LAT_ST = 8'h02;
  localparam logic [7:0] LAT_BCD_MIN = 8'h39;
  localparam logic [7:0] LAT_BCD_MAX = 8'h3F;
  localparam logic [7:0] LAT_I32_MIN = 8'h08;
  localparam logic [7:0] LAT_I32_MAX = 8'h0D;
  localparam logic [7:0] LAT_I16_MIN = 8'h07;
  localparam logic [7:0] LAT_I16_MAX = 8'h0A;
  localparam logic [7:0] LAT_I64_MIN = 8'h0A;
  localparam logic [7:0] LAT_I64_MAX = 8'h0D;
  localparam logic [7:0] LAT_CW = 8'h03;
  localparam logic [7:0] LAT_CW_W = 8'h05;
  localparam logic [7:0] LAT_ENV_MIN = 8'h0C;
  localparam logic [7:0] LAT_ENV_MAX = 8'h16;
  localparam logic [7:0] LAT_ENV_W_MIN = 8'h0E;
  localparam logic [7:0] LAT_ENV_W_MAX = 8'h18;
  localparam logic [7:0] LAT_SW = 8'h04;
  localparam logic [7:0] LAT_SW_W = 8'h06;
  localparam logic [7:0] LAT_AX = 8'h02;
  localparam logic [7:0] LAT_AX_W = 8'h04;
  localparam logic [7:0] LAT_SUB_MIN = 8'h04;
  localparam logic [7:0] LAT_SUB_MAX = 8'h07;
  localparam logic [7:0] LAT_IS_MIN = 8'h0E;
  localparam logic [7:0] LAT_IS32_MAX = 8'h1D;
  localparam logic [7:0] LAT_IS16_MAX = 8'h1B;
  localparam logic [7:0] LAT_CMP = 8'h04;
  localparam logic [7:0] LAT_WAIT = 8'h02;
  localparam logic [7:0] LAT_XCH = 8'h02;
  localparam logic [7:0] LAT_XTR_MIN = 8'h0B;
  localparam logic [7:0] LAT_XTR_MAX = 8'h10;
  localparam logic [7:0] LAT_L2X_MIN = 8'h91;
  localparam logic [7:0] LAT_L2X_MAX = 8'h9A;
  localparam logic [7:0] LAT_L2P_MIN = 8'h83;
  localparam logic [7:0] LAT_L2P_MAX = 8'h85;
  localparam logic [7:0] LAT_L2P_FB = 8'hAA;
  localparam logic [7:0] LAT_RED = 8'h5A;
  localparam logic [7:0] LAT_SIN_MIN = 8'h4C;
  localparam logic [7:0] LAT_SIN_MAX = 8'h8C;
  localparam logic [7:0] LAT_SIN_S_MIN = 8'h51;
  localparam logic [7:0] LAT_SIN_S_MAX = 8'h52;
  localparam logic [7:0] LAT_COS_MIN = 8'h5C;
  localparam logic [7:0] LAT_COS_MAX = 8'h8D;
  localparam logic [7:0] LAT_TAN_MIN = 8'h75;
  localparam logic [7:0] LAT_TAN_MAX = 8'h81;
  localparam logic [7:0] LAT_SC_MIN = 8'h91;
  localparam logic [7:0] LAT_SC_MAX = 8'hA1;
  localparam logic [7:0] LAT_AT_MIN = 8'h61;
  localparam logic [7:0] LAT_AT_MAX = 8'hA1;
  localparam logic [7:0] LAT_RSVD = 8'h02;
  localparam logic [7:0] LAT_UNK = 8'h01;
  localparam logic [2:0] TOP_RST = 3'h0;

  // Decode flags: element operand, pop, double pop, push, condition codes.
  localparam logic [4:0] F_NONE = 5'h00;
  localparam logic [4:0] F_N = 5'h10;
  localparam logic [4:0] F_POP = 5'h08;
  localparam logic [4:0] F_POP2 = 5'h04;
  localparam logic [4:0] F_PUSH = 5'h02;
  localparam logic [4:0] F_CC = 5'h01;

  typedef enum logic [4:0] {
    OP_NONE, OP_STORE, OP_STORE_POP, OP_STORE_INT, OP_STORE_BCD,
    OP_STORE_CW, OP_STORE_ENV, OP_STORE_SW, OP_STORE_AX, OP_SUB,
    OP_SUBR, OP_ISUB, OP_TEST, OP_COMPARE, OP_EXAM, OP_WAIT, OP_EXCH,
    OP_EXTRACT, OP_LOG, OP_LOGP1, OP_SIN, OP_COS, OP_TAN, OP_SINCOS,
    OP_ATAN, OP_RESERVED
  } fssct_op_e;

  typedef struct packed {
    fssct_op_e op;
    logic [7:0] lmin;
    logic [7:0] lmax;
    logic [4:0] fl;
  } fssct_dec_s;

endpackage
`default_nettype wire

// ==== fssct_stack_ptr.sv ====
/*
  Three-bit register-stack top pointer moved by pops and pushes.
  Assumes at most one adjustment request per clock from the decoder.
*/
`timescale 1ns/1ps
`default_nettype none
module fssct_stack_ptr
  import fssct_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pop_i,
  input wire logic pop2_i,
  input wire logic push_i,
  output logic [2:0] top_o
);
  import fssct_pkg::*;

  typedef struct packed {
    logic [2:0] top;
  } fssct_sp_s;

  fssct_sp_s st_r;
  fssct_sp_s st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (pop2_i)
      st_nxt.top = st_r.top + 3'h2;
    else if (pop_i)
      st_nxt.top = st_r.top + 3'h1;
    else if (push_i)
      st_nxt.top = st_r.top - 3'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_r.top <= TOP_RST;
    else
      st_r <= st_nxt;
  end

  assign top_o = st_r.top;
endmodule
`default_nettype wire

// ==== fssct_busy_timer.sv ====
/*
  Busy timer: loaded with a clock count, holds busy for exactly that many
  cycles, then pulses done. Assumes load only arrives while ready is high.
*/
`timescale 1ns/1ps
`default_nettype none
module fssct_busy_timer #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [W-1:0] count_i,
  output logic busy_o,
  output logic ready_o,
  output logic done_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic busy;
    logic ready;
    logic done;
  } fssct_tm_s;

  fssct_tm_s st_r;
  fssct_tm_s st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (load_i)
    begin
      st_nxt.cnt = count_i;
      st_nxt.busy = 1'b1;
      st_nxt.ready = 1'b0;
    end
    else if (st_r.busy)
    begin
      st_nxt.cnt = st_r.cnt - {{(W-1){1'b0}}, 1'b1};
      if (st_r.cnt == {{(W-1){1'b0}}, 1'b1})
      begin
        st_nxt.busy = 1'b0;
        st_nxt.ready = 1'b1;
        st_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r.cnt <= '0;
      st_r.busy <= 1'b0;
      st_r.ready <= 1'b1;
      st_r.done <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  assign busy_o = st_r.busy;
  assign ready_o = st_r.ready;
  assign done_o = st_r.done;
endmodule
`default_nettype wire

// ==== fssct_decoder.sv ====
/*
  Decoder and execution timer for the store, subtract, compare, exchange,
  extract, wait, logarithm and trig opcode group of the floating point
  unit. Assumes the integer unit offers one opcode with valid and stalls
  while ready is low; data-dependent range flags come from the datapath
  on the same clock.
*/
// How it works
// - element operands are indexed from the stack top before execution.
// - a pop discards the value and adds one to the top pointer.
// - a push subtracts one from the top pointer first.
// - ten reserved opcodes run without exception; results are undefined.
// - decimal store writes eighteen digits then pops, 57 to 63 clocks.
// - store-and-pop to element n takes two clocks, like real stores.
// - 64-bit integer store-and-pop takes ten to thirteen clocks.
// - control-word store takes five clocks waiting, three not waiting.
// - environment store takes 12 to 22, or 14 to 24 when waiting.
// - status to accumulator takes two clocks, four when waiting.
// - subtract-and-pop sets element n minus top, pops, 4 to 7 clocks.
// - reverse subtract swaps operand order, 4 to 7 clocks.
// - integer subtract: 14 to 29 for 32-bit, 14 to 27 for 16-bit.
// - test against zero updates condition codes in four clocks.
// - unordered compare sets codes in four clocks; pop form pops once.
// - double-pop compare uses element one and pops twice, four clocks.
// - wait holds issue until not busy and costs two clocks.
// - exchange swaps top with element n in two clocks.
// - exponent extract replaces top then pushes, 11 to 16 clocks.
// - y log2(x+1) takes 131 to 133, or 170 when out of range.
// - sine, cosine, tangent and sincos add 90 clocks when the argument is large.
// - sine takes 81 to 82 clocks for a small argument.
// - arctangent takes 97 clocks for a small ratio.
`timescale 1ns/1ps
`default_nettype none
module fssct_decoder
  import fssct_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic issue_valid_i,
  input wire logic [7:0] op_byte0_i,
  input wire logic [7:0] op_byte1_i,
  input wire logic wait_prefix_i,
  input wire logic [7:0] extra_cycles_i,
  input wire logic arg_large_i,
  input wire logic arg_small_i,
  input wire logic arg_out_of_range_i,
  output logic issue_ready_o,
  output logic busy_o,
  output logic done_o,
  output logic accept_o,
  output fssct_pkg::fssct_op_e op_o,
  output logic [2:0] elem_o,
  output logic [2:0] top_o,
  output logic pop_o,
  output logic pop_two_o,
  output logic push_o,
  output logic cc_update_o,
  output logic reserved_o,
  output logic unknown_o
);
  import fssct_pkg::*;

  ////////////////////////////////////////////////////////////////////////

  function automatic logic is_reserved(input logic [15:0] op);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < RSVD_N; i++)
      if (op == RSVD_OPS[i])
        hit = 1'b1;
    return hit;
  endfunction

  function automatic fssct_dec_s mk(input fssct_op_e op,
    input logic [7:0] lmin, input logic [7:0] lmax, input logic [4:0] fl);
    fssct_dec_s d;
    d.op = op;
    d.lmin = lmin;
    d.lmax = lmax;
    d.fl = fl;
    return d;
  endfunction

  // Ranged counts take the minimum plus the datapath's extra cycles,
  // clamped so the documented maximum is never exceeded.
  function automatic logic [7:0] pick(input logic [7:0] lmin,
    input logic [7:0] lmax, input logic [7:0] extra);
    logic [7:0] span;
    span = lmax - lmin;
    return (extra > span) ? lmax : lmin + extra;
  endfunction

  function automatic fssct_dec_s decode(input logic [7:0] b0,
    input logic [7:0] b1, input logic w);
    fssct_dec_s d;
    logic mem;
    logic [2:0] r;
    d = mk(OP_NONE, LAT_UNK, LAT_UNK, F_NONE);
    mem = (b1[7:6] != 2'b11);
    r = b1[5:3];
    if (b0 == OPB_WAIT)
      d = mk(OP_WAIT, LAT_WAIT, LAT_WAIT, F_NONE);
    else if (is_reserved({b0, b1}))
      d = mk(OP_RESERVED, LAT_RSVD, LAT_RSVD, F_NONE);
    else
    begin
      case (b0)
        OPB_D9:
        begin
          if (mem)
          begin
            case (r)
              3'h2: d = mk(OP_STORE, LAT_ST, LAT_ST, F_NONE);
              3'h3: d = mk(OP_STORE_POP, LAT_ST, LAT_ST, F_POP);
              3'h6: d = w ? mk(OP_STORE_ENV, LAT_ENV_W_MIN, LAT_ENV_W_MAX,
                F_NONE) : mk(OP_STORE_ENV, LAT_ENV_MIN, LAT_ENV_MAX,
                F_NONE);
              3'h7: d = mk(OP_STORE_CW, w ? LAT_CW_W : LAT_CW,
                w ? LAT_CW_W : LAT_CW, F_NONE);
              default: d = mk(OP_NONE, LAT_UNK, LAT_UNK, F_NONE);
            endcase
          end
          else if (b1[7:3] == 5'b11001)
            d = mk(OP_EXCH, LAT_XCH, LAT_XCH, F_N);
          else
          begin
            case (b1)
              8'hE4: d = mk(OP_TEST, LAT_CMP, LAT_CMP, F_CC);
              8'hE5: d = mk(OP_EXAM, LAT_CMP, LAT_CMP, F_CC);
              8'hF4: d = mk(OP_EXTRACT, LAT_XTR_MIN, LAT_XTR_MAX,
                F_PUSH);
              8'hF1: d = mk(OP_LOG, LAT_L2X_MIN, LAT_L2X_MAX, F_POP);
              8'hF9: d = mk(OP_LOGP1, LAT_L2P_MIN, LAT_L2P_MAX, F_POP);
              8'hFE: d = mk(OP_SIN, LAT_SIN_MIN, LAT_SIN_MAX, F_NONE);
              8'hFF: d = mk(OP_COS, LAT_COS_MIN, LAT_COS_MAX, F_NONE);
              8'hF2: d = mk(OP_TAN, LAT_TAN_MIN, LAT_TAN_MAX, F_PUSH);
              8'hFB: d = mk(OP_SINCOS, LAT_SC_MIN, LAT_SC_MAX, F_PUSH);
              8'hF3: d = mk(OP_ATAN, LAT_AT_MIN, LAT_AT_MAX, F_POP);
              default: d = mk(OP_NONE, LAT_UNK, LAT_UNK, F_NONE);
            endcase
          end
        end
        OPB_DB:
        begin
          if (!mem && b1[7:3] == 5'b11011)
            d = mk(OP_STORE_POP, LAT_ST, LAT_ST, F_N | F_POP);
          else if (mem && r == 3'h7)
            d = mk(OP_STORE_POP, LAT_ST, LAT_ST, F_POP);
          else if (mem && r == 3'h2)
            d = mk(OP_STORE_INT, LAT_I32_MIN, LAT_I32_MAX, F_NONE);
          else if (mem && r == 3'h3)
            d = mk(OP_STORE_INT, LAT_I32_MIN, LAT_I32_MAX, F_POP);
        end
        OPB_DD:
        begin
          if (mem)
          begin
            case (r)
              3'h2: d = mk(OP_STORE, LAT_ST, LAT_ST, F_NONE);
              3'h3: d = mk(OP_STORE_POP, LAT_ST, LAT_ST, F_POP);
              3'h7: d = mk(OP_STORE_SW, w ? LAT_SW_W : LAT_SW,
                w ? LAT_SW_W : LAT_SW, F_NONE);
              default: d = mk(OP_NONE, LAT_UNK, LAT_UNK, F_NONE);
            endcase
          end
          else if (b1[7:3] == 5'b11010)
            d = mk(OP_STORE, LAT_ST, LAT_ST, F_N);
          else if (b1[7:3] == 5'b11100)
            d = mk(OP_COMPARE, LAT_CMP, LAT_CMP, F_N | F_CC);
          else if (b1[7:3] == 5'b11101)
            d = mk(OP_COMPARE, LAT_CMP, LAT_CMP,
              F_N | F_CC | F_POP);
        end
        OPB_DF:
        begin
          if (!mem && b1 == 8'hE0)
            d = mk(OP_STORE_AX, w ? LAT_AX_W : LAT_AX,
              w ? LAT_AX_W : LAT_AX, F_NONE);
          else if (mem && r == 3'h6)
            d = mk(OP_STORE_BCD, LAT_BCD_MIN, LAT_BCD_MAX, F_POP);
          else if (mem && r == 3'h7)
            d = mk(OP_STORE_INT, LAT_I64_MIN, LAT_I64_MAX, F_POP);
          else if (mem && r == 3'h2)
            d = mk(OP_STORE_INT, LAT_I16_MIN, LAT_I16_MAX, F_NONE);
          else if (mem && r == 3'h3)
            d = mk(OP_STORE_INT, LAT_I16_MIN, LAT_I16_MAX, F_POP);
        end
        OPB_D8, OPB_DC:
        begin
          // The register form's direction bit flips between D8 and DC.
          if (mem && r == 3'h4)
            d = mk(OP_SUB, LAT_SUB_MIN, LAT_SUB_MAX, F_NONE);
          else if (mem && r == 3'h5)
            d = mk(OP_SUBR, LAT_SUB_MIN, LAT_SUB_MAX, F_NONE);
          else if (!mem && b1[7:4] == 4'hE)
            d = mk((b1[3] ^ (b0 == OPB_D8)) ? OP_SUB : OP_SUBR,
              LAT_SUB_MIN, LAT_SUB_MAX, F_N);
        end
        OPB_DE:
        begin
          if (!mem && b1[7:3] == 5'b11101)
            d = mk(OP_SUB, LAT_SUB_MIN, LAT_SUB_MAX,
              F_N | F_POP);
          else if (!mem && b1[7:3] == 5'b11100)
            d = mk(OP_SUBR, LAT_SUB_MIN, LAT_SUB_MAX,
              F_N | F_POP);
          else if (mem && (r == 3'h4 || r == 3'h5))
            d = mk(OP_ISUB, LAT_IS_MIN, LAT_IS16_MAX, F_NONE);
        end
        OPB_DA:
        begin
          if (!mem && b1 == 8'hE9)
            d = mk(OP_COMPARE, LAT_CMP, LAT_CMP,
              F_CC | F_POP2);
          else if (mem && (r == 3'h4 || r == 3'h5))
            d = mk(OP_ISUB, LAT_IS_MIN, LAT_IS32_MAX, F_NONE);
        end
        default: d = mk(OP_NONE, LAT_UNK, LAT_UNK, F_NONE);
      endcase
    end
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic accept;
    fssct_op_e op;
    logic wait_form;
    logic [2:0] elem;
    logic [2:0] sel_n;
    logic pop;
    logic pop2;
    logic push;
    logic cc;
    logic reserved;
    logic unknown;
    logic [7:0] run_len;
  } fssct_dc_s;

  fssct_dc_s st_r;
  fssct_dc_s st_nxt;
  fssct_dec_s dec;
  logic take;
  logic [7:0] lat;
  logic tm_busy;
  logic tm_ready;
  logic tm_done;
  logic [2:0] top;

  assign take = issue_valid_i && tm_ready;

  always_comb
  begin
    dec = decode(op_byte0_i, op_byte1_i, wait_prefix_i);
    lat = pick(dec.lmin, dec.lmax, extra_cycles_i);
    case (dec.op)
      OP_LOGP1:
        if (arg_out_of_range_i)
          lat = LAT_L2P_FB;
      OP_SIN:
        if (arg_large_i)
          lat = pick(dec.lmin, dec.lmax, extra_cycles_i) + LAT_RED;
        else if (arg_small_i)
          lat = pick(LAT_SIN_S_MIN, LAT_SIN_S_MAX, extra_cycles_i);
      OP_COS, OP_TAN, OP_SINCOS:
        if (arg_large_i)
          lat = pick(dec.lmin, dec.lmax, extra_cycles_i) + LAT_RED;
      OP_ATAN:
        if (arg_small_i)
          lat = LAT_AT_MIN;
      default: lat = pick(dec.lmin, dec.lmax, extra_cycles_i);
    endcase
  end

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.accept = take;
    st_nxt.pop = 1'b0;
    st_nxt.pop2 = 1'b0;
    st_nxt.push = 1'b0;
    st_nxt.cc = 1'b0;
    st_nxt.reserved = 1'b0;
    st_nxt.unknown = 1'b0;
    if (tm_busy)
      st_nxt.run_len = st_r.run_len + 8'h01;
    if (take)
    begin
      st_nxt.op = dec.op;
      st_nxt.wait_form = wait_prefix_i;
      st_nxt.sel_n = (dec.op == OP_COMPARE && (dec.fl & F_POP2) != 5'h00)
        ? 3'h1 : op_byte1_i[2:0];
      // Element operand resolves against the pointer before any pop.
      st_nxt.elem = ((dec.fl & (F_N | F_POP2)) != 5'h00)
        ? top + st_nxt.sel_n : top;
      st_nxt.pop = (dec.fl & F_POP) != 5'h00;
      st_nxt.pop2 = (dec.fl & F_POP2) != 5'h00;
      st_nxt.push = (dec.fl & F_PUSH) != 5'h00;
      st_nxt.cc = (dec.fl & F_CC) != 5'h00;
      st_nxt.reserved = dec.op == OP_RESERVED;
      st_nxt.unknown = dec.op == OP_NONE;
      st_nxt.run_len = 8'h00;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r.accept <= 1'b0;
      st_r.op <= OP_NONE;
      st_r.wait_form <= 1'b0;
      st_r.elem <= TOP_RST;
      st_r.sel_n <= 3'h0;
      st_r.pop <= 1'b0;
      st_r.pop2 <= 1'b0;
      st_r.push <= 1'b0;
      st_r.cc <= 1'b0;
      st_r.reserved <= 1'b0;
      st_r.unknown <= 1'b0;
      st_r.run_len <= 8'h00;
    end
    else
      st_r <= st_nxt;
  end

  fssct_busy_timer #(
    .W(8)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(take),
    .count_i(lat),
    .busy_o(tm_busy),
    .ready_o(tm_ready),
    .done_o(tm_done)
  );

  fssct_stack_ptr u_stack (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pop_i(take && st_nxt.pop),
    .pop2_i(take && st_nxt.pop2),
    .push_i(take && st_nxt.push),
    .top_o(top)
  );

  assign issue_ready_o = tm_ready;
  assign busy_o = tm_busy;
  assign done_o = tm_done;
  assign accept_o = st_r.accept;
  assign op_o = st_r.op;
  assign elem_o = st_r.elem;
  assign top_o = top;
  assign pop_o = st_r.pop;
  assign pop_two_o = st_r.pop2;
  assign push_o = st_r.push;
  assign cc_update_o = st_r.cc;
  assign reserved_o = st_r.reserved;
  assign unknown_o = st_r.unknown;

  ////////////////////////////////////////////////////////////////////////

  property p_elem_before;
    @(posedge clk_i) disable iff (rst_i)
    accept_o && (op_o == OP_EXCH) |->
      (elem_o - $past(top_o)) == st_r.sel_n;
  endproperty
  a_elem_before: assert property (p_elem_before)
    else $error("element index not taken from the old top");

  property p_pop_inc;
    @(posedge clk_i) disable iff (rst_i)
    pop_o |-> (top_o - $past(top_o)) == 3'h1;
  endproperty
  a_pop_inc: assert property (p_pop_inc)
    else $error("pop did not add one to the top pointer");

  property p_push_dec;
    @(posedge clk_i) disable iff (rst_i)
    push_o |-> ($past(top_o) - top_o) == 3'h1;
  endproperty
  a_push_dec: assert property (p_push_dec)
    else $error("push did not subtract one from the top pointer");

  property p_pop_two;
    @(posedge clk_i) disable iff (rst_i)
    pop_two_o |-> (top_o - $past(top_o)) == 3'h2 && cc_update_o
      ##1 busy_o[*3] ##1 !busy_o;
  endproperty
  a_pop_two: assert property (p_pop_two)
    else $error("double-pop compare wrong pointer or timing");

  property p_cw_wait;
    @(posedge clk_i) disable iff (rst_i)
    accept_o && op_o == OP_STORE_CW && st_r.wait_form |->
      busy_o[*5] ##1 !busy_o;
  endproperty
  a_cw_wait: assert property (p_cw_wait)
    else $error("waiting control store not five clocks");

  property p_ax_nowait;
    @(posedge clk_i) disable iff (rst_i)
    accept_o && op_o == OP_STORE_AX && !st_r.wait_form |->
      busy_o[*2] ##1 !busy_o;
  endproperty
  a_ax_nowait: assert property (p_ax_nowait)
    else $error("status to accumulator not two clocks");

  property p_test_four;
    @(posedge clk_i) disable iff (rst_i)
    accept_o && op_o == OP_TEST |-> cc_update_o ##0 busy_o[*4] ##1 !busy_o;
  endproperty
  a_test_four: assert property (p_test_four)
    else $error("test against zero not four clocks");

  property p_wait_issue;
    @(posedge clk_i) disable iff (rst_i)
    busy_o |-> !issue_ready_o ##1 !accept_o;
  endproperty
  a_wait_issue: assert property (p_wait_issue)
    else $error("issue taken while busy");

  property p_bcd_len;
    @(posedge clk_i) disable iff (rst_i)
    done_o && op_o == OP_STORE_BCD |->
      st_r.run_len >= LAT_BCD_MIN && st_r.run_len <= LAT_BCD_MAX;
  endproperty
  a_bcd_len: assert property (p_bcd_len)
    else $error("decimal store busy length out of range");

  property p_isub_len;
    @(posedge clk_i) disable iff (rst_i)
    done_o && op_o == OP_ISUB |->
      st_r.run_len >= LAT_IS_MIN && st_r.run_len <= LAT_IS32_MAX;
  endproperty
  a_isub_len: assert property (p_isub_len)
    else $error("integer subtract busy length out of range");

  property p_rsvd_quiet;
    @(posedge clk_i) disable iff (rst_i)
    reserved_o |-> !unknown_o && busy_o[*2] ##1 done_o;
  endproperty
  a_rsvd_quiet: assert property (p_rsvd_quiet)
    else $error("reserved opcode not run quietly");
endmodule
`default_nettype wire

// ==== fssct_issuer.sv ====
/* Integer unit model: offers one opcode {wait, byte0, byte1} and holds it.
   Assumes the bench requests only while no opcode is pending. */
`timescale 1ns/1ps
`default_nettype none
module fssct_issuer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ready_i,
  input wire logic req_i,
  input wire logic [16:0] op_i,
  output logic valid_o,
  output logic [16:0] op_o
);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      valid_o <= 1'b0;
    else if (valid_o && ready_i)
    begin
      // Inverted lines after release keep a stale opcode from passing.
      valid_o <= 1'b0;
      op_o <= ~op_o;
    end
    else if (req_i && !valid_o)
    begin
      valid_o <= 1'b1;
      op_o <= op_i;
    end
  end
endmodule
`default_nettype wire

// ==== fpu_store_sub_compare_timing_bench.sv ====
/* Bench: runs opcodes through the issuer and compares busy time, stack
   moves and flags with a model. Assumes the handed-over counts and reset. */
`timescale 1ns/1ps
`default_nettype none
module fpu_store_sub_compare_timing_bench;
  import fssct_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req = 1'b0;
  logic [16:0] op_in = 17'h0_0000;
  logic [16:0] op_out;
  logic [7:0] extra = 8'h00;
  logic [2:0] arg = 3'h0;
  logic valid, rdy, busy, done, acc, pop, pop2, push, cc, rsv, unk;
  logic [2:0] elem, top;
  fssct_op_e opo;
  int miscompares = 0;
  int check_count = 0;
  int seed = 46502;
  int mtop = 0;
  fssct_issuer u_iss (.clk_i(clk_i), .rst_i(rst_i), .ready_i(rdy),
    .req_i(req), .op_i(op_in), .valid_o(valid), .op_o(op_out));
  fssct_decoder DUT (.clk_i(clk_i), .rst_i(rst_i), .issue_valid_i(valid),
    .op_byte0_i(op_out[15:8]), .op_byte1_i(op_out[7:0]),
    .wait_prefix_i(op_out[16]), .extra_cycles_i(extra),
    .arg_large_i(arg[0]), .arg_small_i(arg[1]), .arg_out_of_range_i(arg[2]),
    .issue_ready_o(rdy), .busy_o(busy), .done_o(done), .accept_o(acc),
    .op_o(opo), .elem_o(elem), .top_o(top), .pop_o(pop), .pop_two_o(pop2),
    .push_o(push), .cc_update_o(cc), .reserved_o(rsv), .unknown_o(unk));
  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    begin
      if (miscompares == 0 && check_count > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    begin
      check_count++;
      if (g !== e)
      begin
        miscompares++;
        $display("ERROR %s expected %0h seen %0h", nm, e, g);
      end
    end
  endtask
  // Flags fl: pop, double pop, push, codes, reserved, unknown; eo < 0
  // skips the operand index, which is meaningless for those opcodes.
  task automatic t(input logic [16:0] o, input int lo, input int hi,
    input int fl, input int eo, input logic [2:0] a, input fssct_op_e c);
    int n;
    int k;
    logic [7:0] e;
    begin
      e = 8'($random(seed));
      @(posedge clk_i);
      req <= 1'b1;
      op_in <= o;
      extra <= e;
      arg <= a;
      @(posedge clk_i);
      req <= 1'b0;
      k = 0;
      do
      begin
        @(negedge clk_i);
        k++;
      end
      while (acc !== 1'b1 && k < 9);
      n = lo + ((e > hi - lo) ? hi - lo : e) + (a[0] ? 90 : 0);
      chk("flags", 8'(fl), {2'h0, unk, rsv, cc, push, pop2, pop});
      chk("op", 8'(c), {3'h0, opo});
      chk("ready", 8'h00, {7'h00, rdy});
      if (eo >= 0)
        chk("elem", 8'((mtop + eo) & 7), {5'h00, elem});
      mtop = (mtop + fl[0] + 2 * fl[1] - fl[2]) & 7;
      chk("top", 8'(mtop), {5'h00, top});
      k = 0;
      while (busy === 1'b1 && k < 300)
      begin
        k++;
        @(negedge clk_i);
      end
      chk("cycles", 8'(n), 8'(k));
      chk("done", 8'h01, {7'h00, done});
      chk("ready", 8'h01, {7'h00, rdy});
    end
  endtask
  initial
  begin
    forever #25 clk_i = ~clk_i;
  end
  initial
  begin
    #1_000_000;
    miscompares++;
    results();
  end
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t(17'h0_DFE0, 2, 2, 0, 0, 3'h0, OP_STORE_AX);
    t(17'h1_DFE0, 4, 4, 0, 0, 3'h0, OP_STORE_AX);
    t(17'h0_DF30, 57, 63, 1, 0, 3'h0, OP_STORE_BCD);
    t(17'h0_DBDD, 2, 2, 1, 5, 3'h0, OP_STORE_POP);
    t(17'h0_D910, 2, 2, 0, 0, 3'h0, OP_STORE);
    t(17'h0_DB38, 2, 2, 1, 0, 3'h0, OP_STORE_POP);
    t(17'h0_DDD3, 2, 2, 0, 3, 3'h0, OP_STORE);
    t(17'h0_DF38, 10, 13, 1, 0, 3'h0, OP_STORE_INT);
    t(17'h0_DB10, 8, 13, 0, 0, 3'h0, OP_STORE_INT);
    t(17'h0_DF18, 7, 10, 1, 0, 3'h0, OP_STORE_INT);
    t(17'h0_D938, 3, 3, 0, 0, 3'h0, OP_STORE_CW);
    t(17'h1_D938, 5, 5, 0, 0, 3'h0, OP_STORE_CW);
    t(17'h0_D930, 12, 22, 0, 0, 3'h0, OP_STORE_ENV);
    t(17'h1_D930, 14, 24, 0, 0, 3'h0, OP_STORE_ENV);
    t(17'h1_DD38, 6, 6, 0, 0, 3'h0, OP_STORE_SW);
    t(17'h0_DEEB, 4, 7, 1, 3, 3'h0, OP_SUB);
    t(17'h0_DC28, 4, 7, 0, 0, 3'h0, OP_SUBR);
    t(17'h0_DEE3, 4, 7, 1, 3, 3'h0, OP_SUBR);
    t(17'h0_D8E9, 4, 7, 0, 1, 3'h0, OP_SUBR);
    t(17'h0_DCEA, 4, 7, 0, 2, 3'h0, OP_SUB);
    t(17'h0_DA20, 14, 29, 0, 0, 3'h0, OP_ISUB);
    t(17'h0_DE28, 14, 27, 0, 0, 3'h0, OP_ISUB);
    t(17'h0_D9E4, 4, 4, 8, 0, 3'h0, OP_TEST);
    t(17'h0_D9E5, 4, 4, 8, 0, 3'h0, OP_EXAM);
    t(17'h0_DDE2, 4, 4, 8, 2, 3'h0, OP_COMPARE);
    t(17'h0_DDEF, 4, 4, 9, 7, 3'h0, OP_COMPARE);
    t(17'h0_DAE9, 4, 4, 10, 1, 3'h0, OP_COMPARE);
    t(17'h0_9B00, 2, 2, 0, -1, 3'h0, OP_WAIT);
    t(17'h0_D9CE, 2, 2, 0, 6, 3'h0, OP_EXCH);
    t(17'h0_D9F4, 11, 16, 4, 0, 3'h0, OP_EXTRACT);
    t(17'h0_D9F1, 145, 154, 1, 0, 3'h0, OP_LOG);
    t(17'h0_D9F9, 131, 133, 1, 0, 3'h0, OP_LOGP1);
    t(17'h0_D9F9, 170, 170, 1, 0, 3'h4, OP_LOGP1);
    t(17'h0_D9FE, 76, 140, 0, 0, 3'h1, OP_SIN);
    t(17'h0_D9FB, 145, 161, 4, 0, 3'h1, OP_SINCOS);
    t(17'h0_D9FF, 92, 141, 0, 0, 3'h1, OP_COS);
    t(17'h0_D9F2, 117, 129, 4, 0, 3'h1, OP_TAN);
    t(17'h0_D9FE, 81, 82, 0, 0, 3'h2, OP_SIN);
    t(17'h0_D9F3, 97, 97, 1, 0, 3'h2, OP_ATAN);
    t(17'h0_D8C0, 1, 1, 32, -1, 3'h0, OP_NONE);
    for (int i = 0; i < RSVD_N; i++)
      t({1'b0, RSVD_OPS[i]}, 2, 2, 16, -1, 3'h0, OP_RESERVED);
    results();
  end
endmodule
`default_nettype wire
